/* verilog/ncm_cfg.svh */
`ifndef NCM_CFG_SVH
`define NCM_CFG_SVH

// Widths of the stored word and of the multiplexed group
`define NCM_DATA_W 5
`define NCM_MUX_W 4
`define NCM_FIFTH_BIT 4
`define NCM_SYNC_W 9

// Fixed slave address and the reserved upper bits of a data byte
`define NCM_SLAVE_ADDR 7'h4E
`define NCM_RSVD_MSB 7
`define NCM_RSVD_LSB 5
`define NCM_RSVD_ZERO 3'h0
`define NCM_BYTE_BITS 4'h8
`define NCM_CNT_ZERO 4'h0
`define NCM_CNT_ONE 4'h1

// Nonvolatile write time; arbitrary default, the value is not documented
`define NCM_CLK_NS 8
`define NCM_WR_TIME_NS 5000
`define NCM_WR_CYCLES ((`NCM_WR_TIME_NS + `NCM_CLK_NS - 1) / `NCM_CLK_NS)
`define NCM_WR_CNT_W 10

// As-delivered contents of the stored word
`define NCM_NV_INIT 5'h00

`endif

/* verilog/ncm_pkg.sv */
`include "ncm_cfg.svh"

package ncm_pkg;

    typedef enum logic [2:0] {
        NCM_IDLE,
        NCM_ADDR,
        NCM_AACK,
        NCM_WDATA,
        NCM_WACK,
        NCM_RDATA,
        NCM_RACK
    } ncm_state_t;

    typedef struct packed {
        logic req;
        logic [`NCM_DATA_W-1:0] data;
    } ncm_wr_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } ncm_line_t;

endpackage

/* verilog/ncm_nvreg.sv */
`timescale 1ns/100ps
`include "ncm_cfg.svh"

module ncm_nvreg (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ncm_pkg::ncm_wr_t wr_i,
    output logic [`NCM_DATA_W-1:0] data_o,
    output logic busy_o
);
    import ncm_pkg::*;

    localparam logic [`NCM_WR_CNT_W-1:0] WR_CYCLES =
        `NCM_WR_CNT_W'(`NCM_WR_CYCLES);

    // Stored bits are not reset: they model the nonvolatile array
    logic [`NCM_DATA_W-1:0] stored_r = `NCM_NV_INIT;
    logic [`NCM_DATA_W-1:0] stored_nxt;
    logic [`NCM_DATA_W-1:0] pend_r;
    logic [`NCM_DATA_W-1:0] pend_nxt;
    logic [`NCM_WR_CNT_W-1:0] cnt_r;
    logic [`NCM_WR_CNT_W-1:0] cnt_nxt;
    logic busy_r;
    logic busy_nxt;

    always_comb begin
        stored_nxt = stored_r;
        pend_nxt = pend_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        if (busy_r) begin
            if (cnt_r == WR_CYCLES) begin
                // Old contents stay visible until the write completes
                stored_nxt = pend_r;
                busy_nxt = 1'b0;
            end else begin
                cnt_nxt = cnt_r + `NCM_WR_CNT_W'(1);
            end
        end else if (wr_i.req) begin
            pend_nxt = wr_i.data;
            busy_nxt = 1'b1;
            cnt_nxt = `NCM_WR_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        stored_r <= stored_nxt;
        pend_r <= pend_nxt;
        if (rst_i) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign data_o = stored_r;
    assign busy_o = busy_r;

endmodule

/* verilog/ncm_top.sv */
`timescale 1ns/100ps
`include "ncm_cfg.svh"

// Operation
// - Five stored bits: four muxed, one separate
// - Stored word reads zero as delivered
// - Stored word reached only over the serial port
// - Slave only, clock input, standard and fast
// - Write protect keeps stored word unchanged
// - Force-low input zeroes register-sourced outputs
// - Path select chooses pass inputs or register
// - Fifth output captured on path select rise
// - Fifth output held during nonvolatile write
// - Answer own fixed address only, no general call
// - Upper three bits zero; first valid byte commits
// - Commit needs write and protect low at ack
// - Address ignored, old value shown while writing
module ncm_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic wp_i,
    input wire logic force_low_n_i,
    input wire logic path_select_i,
    input wire logic [`NCM_MUX_W-1:0] pass_inputs_i,
    output logic [`NCM_MUX_W-1:0] selected_outputs_o,
    output logic held_fifth_output_o
);
    import ncm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [`NCM_SYNC_W-1:0] raw;
    logic [`NCM_SYNC_W-1:0] meta_r;
    logic [`NCM_SYNC_W-1:0] sync_r;
    ncm_line_t line_s;
    ncm_line_t line_d_r;
    logic wp_s;
    logic fl_n_s;
    logic psel_s;
    logic [`NCM_MUX_W-1:0] pass_s;

    always_comb begin
        raw = {scl_i, sda_i, wp_i, force_low_n_i, path_select_i,
               pass_inputs_i};
    end

    // Not reset: three reset edges fill them from the pins, so the edge
    // detector starts from the real line levels and sees no false edge
    always_ff @(posedge clk_i) begin
        meta_r <= raw;
        sync_r <= meta_r;
        line_d_r <= line_s;
    end

    assign {line_s, wp_s, fl_n_s, psel_s, pass_s} = sync_r;

    ////////////////////////////////////////////////////////////////////////
    // Bus events

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    // SCL is only sensed, never driven
    assign scl_rise = line_s.scl & ~line_d_r.scl;
    assign scl_fall = ~line_s.scl & line_d_r.scl;
    assign start_ev = line_s.scl & line_d_r.scl & line_d_r.sda & ~line_s.sda;
    assign stop_ev = line_s.scl & line_d_r.scl & ~line_d_r.sda & line_s.sda;

    ////////////////////////////////////////////////////////////////////////
    // Nonvolatile store

    ncm_wr_t wr_r;
    ncm_wr_t wr_nxt;
    logic [`NCM_DATA_W-1:0] nv_data;
    logic nv_busy;

    ncm_nvreg u_nvreg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_r),
        .data_o(nv_data),
        .busy_o(nv_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serial slave

    ncm_state_t st_r;
    ncm_state_t st_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic rw_r;
    logic rw_nxt;
    logic nack_r;
    logic nack_nxt;
    logic have_r;
    logic have_nxt;
    logic wp_ok_r;
    logic wp_ok_nxt;
    logic [`NCM_DATA_W-1:0] data_r;
    logic [`NCM_DATA_W-1:0] data_nxt;
    logic oe_r;
    logic oe_nxt;
    logic [7:0] rd_byte;
    logic byte_valid;

    assign rd_byte = {`NCM_RSVD_ZERO, nv_data};
    assign byte_valid = (shift_r[`NCM_RSVD_MSB:`NCM_RSVD_LSB] ==
                         `NCM_RSVD_ZERO);

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        rw_nxt = rw_r;
        nack_nxt = nack_r;
        have_nxt = have_r;
        wp_ok_nxt = wp_ok_r;
        data_nxt = data_r;
        oe_nxt = oe_r;
        wr_nxt = '0;
        if (stop_ev) begin
            // Commit once at stop, only for a protected-off write
            if (have_r && wp_ok_r && !rw_r) begin
                wr_nxt.req = 1'b1;
                wr_nxt.data = data_r;
            end
            st_nxt = NCM_IDLE;
            oe_nxt = 1'b0;
            have_nxt = 1'b0;
        end else if (start_ev) begin
            // A busy store leaves the bus unanswered
            st_nxt = nv_busy ? NCM_IDLE : NCM_ADDR;
            cnt_nxt = `NCM_CNT_ZERO;
            oe_nxt = 1'b0;
            have_nxt = 1'b0;
        end else begin
            case (st_r)
                NCM_ADDR, NCM_WDATA: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], line_s.sda};
                        cnt_nxt = cnt_r + `NCM_CNT_ONE;
                    end else if (scl_fall && cnt_r == `NCM_BYTE_BITS) begin
                        if (st_r == NCM_WDATA) begin
                            // Every data byte is acknowledged
                            oe_nxt = 1'b1;
                            st_nxt = NCM_WACK;
                        end else if (shift_r[7:1] == `NCM_SLAVE_ADDR &&
                                     !nv_busy) begin
                            oe_nxt = 1'b1;
                            rw_nxt = shift_r[0];
                            st_nxt = NCM_AACK;
                        end else begin
                            st_nxt = NCM_IDLE;
                        end
                    end
                end
                NCM_AACK, NCM_RACK: begin
                    if (scl_rise) begin
                        nack_nxt = line_s.sda;
                    end else if (scl_fall) begin
                        cnt_nxt = `NCM_CNT_ZERO;
                        if (st_r == NCM_RACK && nack_r) begin
                            oe_nxt = 1'b0;
                            st_nxt = NCM_IDLE;
                        end else if (rw_r) begin
                            shift_nxt = rd_byte;
                            oe_nxt = ~rd_byte[7];
                            st_nxt = NCM_RDATA;
                        end else begin
                            oe_nxt = 1'b0;
                            st_nxt = NCM_WDATA;
                        end
                    end
                end
                NCM_WACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        cnt_nxt = `NCM_CNT_ZERO;
                        st_nxt = NCM_WDATA;
                        // Protect is judged at the end of this ack pulse
                        if (byte_valid && !have_r) begin
                            have_nxt = 1'b1;
                            data_nxt = shift_r[`NCM_DATA_W-1:0];
                            wp_ok_nxt = ~wp_s;
                        end
                    end
                end
                NCM_RDATA: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + `NCM_CNT_ONE;
                    end else if (scl_fall) begin
                        if (cnt_r == `NCM_BYTE_BITS) begin
                            oe_nxt = 1'b0;
                            st_nxt = NCM_RACK;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_nxt = ~shift_r[6];
                        end
                    end
                end
                default: begin
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= NCM_IDLE;
            cnt_r <= `NCM_CNT_ZERO;
            shift_r <= '0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            have_r <= 1'b0;
            wp_ok_r <= 1'b0;
            data_r <= '0;
            oe_r <= 1'b0;
            wr_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            rw_r <= rw_nxt;
            nack_r <= nack_nxt;
            have_r <= have_nxt;
            wp_ok_r <= wp_ok_nxt;
            data_r <= data_nxt;
            oe_r <= oe_nxt;
            wr_r <= wr_nxt;
        end
    end

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_r;

    ////////////////////////////////////////////////////////////////////////
    // Output multiplexer

    logic [`NCM_MUX_W-1:0] sel_r;
    logic [`NCM_MUX_W-1:0] sel_nxt;
    logic fifth_r;
    logic fifth_nxt;
    logic held_r;
    logic held_nxt;
    logic psel_d_r;

    always_comb begin
        held_nxt = held_r;
        if (psel_s && !psel_d_r) begin
            held_nxt = fifth_r;
        end
        if (psel_s) begin
            // Force-low has no say while passing through
            sel_nxt = pass_s;
            fifth_nxt = held_nxt;
        end else if (fl_n_s) begin
            // Store output changes only at write completion
            sel_nxt = nv_data[`NCM_MUX_W-1:0];
            fifth_nxt = nv_data[`NCM_FIFTH_BIT];
        end else begin
            sel_nxt = '0;
            fifth_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_r <= '0;
            fifth_r <= 1'b0;
            held_r <= 1'b0;
            // Track the pin so a select already high is no rising edge
            psel_d_r <= psel_s;
        end else begin
            sel_r <= sel_nxt;
            fifth_r <= fifth_nxt;
            held_r <= held_nxt;
            psel_d_r <= psel_s;
        end
    end

    // Levels are steady before processor reset release if path select is low
    assign selected_outputs_o = sel_r;
    assign held_fifth_output_o = fifth_r;

endmodule

/* test/ncm_top_checker.sv */
`timescale 1ns/100ps
`include "ncm_cfg.svh"

module ncm_top_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic wp_i,
    input wire logic force_low_n_i,
    input wire logic path_select_i,
    input wire logic [`NCM_MUX_W-1:0] pass_inputs_i,
    input wire logic [`NCM_MUX_W-1:0] selected_outputs_o,
    input wire logic held_fifth_output_o
);
    logic scl_r, sda_r;
    logic [9:0] cnt_r, cnt_nxt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Counts from a stop; below 600 no commit can have landed yet
    always_comb begin
        cnt_nxt = cnt_r + 10'h001;
        if (cnt_r == 10'h000)
            cnt_nxt = {9'h000, scl_i && scl_r && sda_i && !sda_r};
        else if (cnt_r == 10'h26C)
            cnt_nxt = 10'h000;
    end
    always_ff @(posedge clk_i) begin
        scl_r <= scl_i;
        sda_r <= sda_i;
        cnt_r <= rst_i ? 10'h000 : cnt_nxt;
    end
    ////////////////////////////////////////////////////////////
    sequence reg_mode5;
        (!path_select_i && force_low_n_i) [*5];
    endsequence
    sequence zero_mode4;
        (!path_select_i && !force_low_n_i) [*4];
    endsequence
    sequence pass_mode4;
        (path_select_i && $stable(pass_inputs_i)) [*4];
    endsequence
    chk_sda_low: assert property (sda_o == 1'b0)
        else $error("sda data output not low");
    chk_ack_scl_low: assert property ($rose(sda_oe_o) |->
        !$past(scl_i, 1) && !$past(scl_i, 2))
        else $error("sda pulled while scl high");
    chk_oe_scl_high: assert property (scl_i && $past(scl_i) &&
        $past(scl_i, 2) && $past(scl_i, 3) |-> $stable(sda_oe_o))
        else $error("sda enable moved while scl high");
    chk_force_zero: assert property (zero_mode4 |->
        selected_outputs_o == 4'h0 && held_fifth_output_o == 1'b0)
        else $error("outputs not forced low");
    chk_pass_follow: assert property (pass_mode4 |->
        selected_outputs_o == pass_inputs_i)
        else $error("outputs do not follow pass inputs");
    chk_held_keep: assert property (path_select_i [*5] |->
        $stable(held_fifth_output_o))
        else $error("held output moved while path select high");
    chk_write_hold: assert property (reg_mode5 ##0
        (cnt_r > 10'h004 && cnt_r < 10'h258) |->
        $stable(selected_outputs_o) && $stable(held_fifth_output_o))
        else $error("outputs moved during write time");
    chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
        sda_oe_o == 1'b0 && selected_outputs_o == 4'h0)
        else $error("outputs active in reset");
endmodule

bind ncm_top ncm_top_checker chk (.clk_i, .rst_i, .scl_i, .sda_i, .sda_o,
    .sda_oe_o, .wp_i, .force_low_n_i, .path_select_i, .pass_inputs_i,
    .selected_outputs_o, .held_fifth_output_o);

/* test/ncm_master.sv */
`timescale 1ns/100ps

module ncm_master (
    input wire logic sda_oe_i,
    input wire logic [3:0] sel_i,
    input wire logic cpu_rst_n_i,
    output logic scl_o,
    output logic sda_o,
    output logic [3:0] cfg_o
);
    logic pull;
    // Open-drain line with pull-up: released means high, never stale
    assign sda_o = !(pull || sda_oe_i);
    // Line changes are non-blocking: one that lands on a clock edge is
    // seen after that edge, never in a race with it
    initial begin
        scl_o <= 1'b1;
        pull <= 1'b0;
    end
    // Processor takes its strap levels as its reset releases
    always @(posedge cpu_rst_n_i) cfg_o <= sel_i;
    ////////////////////////////////////////////////////////////
    // 125 ns bit; SCL stands high between frames
    task automatic bitx(input logic b, output logic r);
        #31.25 pull <= !b;
        #31.25 scl_o <= 1'b1;
        #31.25 r = sda_o;
        #31.25 scl_o <= 1'b0;
    endtask
    task automatic start;
        #31.25 pull <= 1'b0;
        #31.25 scl_o <= 1'b1;
        #31.25 pull <= 1'b1;
        #31.25 scl_o <= 1'b0;
    endtask
    task automatic stop;
        #31.25 pull <= 1'b1;
        #31.25 scl_o <= 1'b1;
        #31.25 pull <= 1'b0;
        #31.25;
    endtask
    task automatic xbyte(input logic [7:0] d, input logic mack,
                         output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(mack, ack);
    endtask
endmodule

/* test/ncm_top_tb.sv */
`timescale 1ns/100ps
`include "ncm_cfg.svh"

module ncm_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wp = 1'b0, fl_n = 1'b1, psel = 1'b0, cpu_rst_n = 1'b1;
    logic hx = 1'b0;
    logic [3:0] pin = 4'h0, sel, cfg;
    logic scl, sda, oe, held;
    logic [4:0] word = 5'h00;
    logic [7:0] q;
    int fails = 0, n_compared = 0;
    always #4 clk_i = ~clk_i;

    ncm_top dut (.clk_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(oe), .wp_i(wp), .force_low_n_i(fl_n),
        .path_select_i(psel), .pass_inputs_i(pin),
        .selected_outputs_o(sel), .held_fifth_output_o(held));
    ncm_master m (.sda_oe_i(oe), .sel_i(sel), .cpu_rst_n_i(cpu_rst_n),
        .scl_o(scl), .sda_o(sda), .cfg_o(cfg));

    task automatic check(input string what, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [4:0] expect_out(logic ps, logic f,
        logic [3:0] p, logic [4:0] w, logic h);
        if (ps) return {h, p};
        return f ? w : 5'h00;
    endfunction
    task automatic look(input logic h);
        repeat (4) @(negedge clk_i);
        check("outputs", {3'h0, held, sel},
            {3'h0, expect_out(psel, fl_n, pin, word, h)});
    endtask
    task automatic xfer(input logic [7:0] a, input logic [23:0] d,
                        input int nb, input logic aack);
        logic ack;
        m.start();
        m.xbyte(a, 1'b1, q, ack);
        check("addr ack", 8'(ack), 8'(!aack));
        for (int i = nb - 1; i >= 0 && aack; i--) begin
            m.xbyte(d[8*i +: 8], 1'b1, q, ack);
            check("data ack", 8'(ack), 8'h00);
        end
        m.stop();
    endtask
    task automatic rd(input logic [4:0] w);
        logic ack;
        m.start();
        m.xbyte(8'h9D, 1'b1, q, ack);
        check("read ack", 8'(ack), 8'h00);
        // Master acknowledge makes the slave send the word again
        m.xbyte(8'hFF, 1'b0, q, ack);
        check("read data", q, {3'h0, w});
        m.xbyte(8'hFF, 1'b1, q, ack);
        m.stop();
        check("read again", q, {3'h0, w});
    endtask
    task automatic settle;
        repeat (700) @(negedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        logic [4:0] v;
        logic [4:0] cur;
        logic [7:0] a;
        void'($urandom(32'h5907C4FA));
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clk_i);
        look(1'b0);
        rd(5'h00);
        $display("reset test done");
        for (int k = 0; k < 3; k++) begin
            v = 5'($urandom);
            xfer(8'h9C, {19'h0, v}, 1, 1'b1);
            xfer(8'h9D, 24'h0, 0, 1'b0);
            look(1'b0);
            word = v;
            settle();
            look(1'b0);
            rd(word);
        end
        @(negedge clk_i);
        wp = 1'b1;
        xfer(8'h9C, {19'h0, ~word}, 1, 1'b1);
        settle();
        look(1'b0);
        wp = 1'b0;
        v = 5'($urandom);
        xfer(8'h9C, {3'h5, v, 3'h0, v, 3'h0, ~v}, 3, 1'b1);
        word = v;
        settle();
        look(1'b0);
        $display("write tests done");
        for (int k = 0; k < 4; k++) begin
            a = (k == 0) ? 8'h00 : {7'($urandom), 1'b0};
            if (a[7:1] == 7'h4E) a = 8'h1C;
            xfer(a, 24'h000001, 0, 1'b0);
        end
        settle();
        look(1'b0);
        $display("address test done");
        for (int k = 0; k < 16; k++) begin
            cur = expect_out(psel, fl_n, pin, word, hx);
            if (!psel && k[1]) hx = cur[4];
            psel = k[1];
            fl_n = k[0] ^ k[2];
            pin = 4'($urandom);
            look(hx);
        end
        v = word ^ 5'h10;
        xfer(8'h9C, {19'h0, v}, 1, 1'b1);
        word = v;
        settle();
        look(hx);
        $display("output test done");
        // Straps must come from storage while the processor leaves reset
        psel = 1'b0;
        fl_n = 1'b1;
        cpu_rst_n = 1'b0;
        repeat (8) @(negedge clk_i);
        cpu_rst_n = 1'b1;
        #1 check("straps", {4'h0, cfg}, {4'h0, word[3:0]});
        $display("strap test done");
        conclude();
    end
    // Tests need about 80 us; allow well over twice that
    initial begin
        #400000;
        fails++;
        conclude();
    end
endmodule
